// ### clk_src_defs.svh
// clock source controller: register offsets, field positions, codes,
// reset values and timing counts
// definitions only; included by the controller and the bench by bare name
`ifndef CLK_SRC_DEFS_SVH
`define CLK_SRC_DEFS_SVH
`define ADR_CTRL 8'h00
`define ADR_DIV 8'h04
`define ADR_FBDIV 8'h08
`define ADR_AUX 8'h0c
`define ADR_STAT 8'h10
`define ADR_MASK 8'h14
`define CTRL_NEW 0
`define CTRL_CUR 4
`define CTRL_SWREQ 8
`define CTRL_LOCK 9
`define DIV_PRE 0
`define DIV_POST 6
`define DIV_FRCDIV 8
`define DIV_DOZEN 11
`define DIV_DOZE 12
`define ST_FAIL 0
`define ST_DONE 1
`define SRC_RC 3'h0
`define SRC_RC_PLL 3'h1
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3
`define SRC_RSVD 3'h4
`define SRC_LOWPWR 3'h5
`define SRC_RC16 3'h6
`define SRC_RC_DIVN 3'h7
`define MODE_EXT 2'h0
`define MODE_CRYSTAL 2'h1
`define MODE_HIGH_SPEED 2'h2
`define RST_PRE 5'h00
`define RST_POST 2'h1
`define RST_FB 9'h000
`define RST_FRCDIV 3'h0
`define RST_DOZE 3'h3
`define RST_AUX 3'h0
`define IN_DIV_ADD 12'h002
`define MUL_ADD 12'h002
`define RC16_RATIO 9'h010
`define CPU_RATIO 9'h002
`define LOCK_TICKS 8'h20
`define CLK_MHZ 50
`define FAIL_SAFE_MONITOR_TIMEOUT_NS 2000
`define FAIL_SAFE_MONITOR_CYCLES ((`FAIL_SAFE_MONITOR_TIMEOUT_NS * `CLK_MHZ) / 1000)
`endif

// ### clk_src_pkg.sv
// clock source controller: shared types
// constants live in clk_src_defs.svh
`default_nettype none
package clk_src_pkg;
	typedef enum logic [1:0] {SW_IDLE, SW_WAIT_OLD, SW_WAIT_NEW} sw_state_type;
	typedef struct packed {
		logic [2:0] doze;
		logic doze_en;
		logic [2:0] frcdiv;
		logic [1:0] post;
		logic [4:0] pre;
	} div_cfg_type;
	typedef struct packed {
		logic [2:0] initial_source_select;
		logic [1:0] primary_osc_mode;
		logic osc_pin_function_bit;
	} boot_cfg_type;
endpackage
`default_nettype wire

// ### tick_divider.sv
// divides a one-cycle tick stream by a run-time ratio
// ratio must be at least one; output is registered
`default_nettype none
module tick_divider #(
	parameter int W = 9
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ticks
	input wire logic in_tick,
	input wire logic [W-1:0] ratio,
	output logic out_tick
);
	logic [W-1:0] cnt_q, cnt_d;
	logic out_d;

	always_comb begin
		cnt_d = cnt_q;
		out_d = 1'b0;
		// >= keeps a lowered ratio from running the count away
		if (in_tick) begin
			if (cnt_q >= ratio - W'(1)) begin
				cnt_d = '0;
				out_d = 1'b1;
			end else begin
				cnt_d = cnt_q + W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			out_tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_tick <= out_d;
		end
	end
endmodule
`default_nettype wire

// ### rate_scaler.sv
// fractional rate scaler: out rate = in rate * mul / div
// at most one output tick per clock; excess rate saturates the accumulator
`default_nettype none
module rate_scaler #(
	parameter int W = 12
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ticks and ratio
	input wire logic in_tick,
	input wire logic [W-1:0] mul,
	input wire logic [W-1:0] div,
	output logic out_tick
);
	logic [W+1:0] acc_q, acc_d, sum;
	logic out_d;

	always_comb begin
		sum = acc_q;
		if (in_tick && !acc_q[W+1]) begin
			sum = acc_q + {2'h0, mul};
		end
		acc_d = sum;
		out_d = 1'b0;
		if (div != '0 && sum >= {2'h0, div}) begin
			acc_d = sum - {2'h0, div};
			out_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_q <= '0;
			out_tick <= 1'b0;
		end else begin
			acc_q <= acc_d;
			out_tick <= out_d;
		end
	end
endmodule
`default_nettype wire

// ### clock_source_ctrl.sv
// clock source controller: source select and glitch-free switching, pll
// rate scaling, cpu and peripheral enables, fail-safe monitor, wishbone regs
// assumes oscillators arrive as asynchronous square waves well below clk/4
`include "clk_src_defs.svh"
`default_nettype none

// Functional notes
// - cpu clock enable runs at half the selected oscillator rate
// - pll input divider ratio is the 5-bit prescaler field plus two
// - pll output divider ratio is twice the 2-bit postscaler field plus two
// - pll feedback multiplier is the 9-bit divisor field plus two
// - pll output rate is input times multiplier over both divider ratios
// - vco rate is input times multiplier over input divider only
// - source codes: 7 rc-divn, 6 rc/16, 5 low-power, 3 pri-pll, 2 pri, 1 rc-pll, 0 rc
// - primary mode picks high-speed, crystal or external; ignored for internal sources
// - an erased device starts on internal rc with programmable divider
// - a dedicated configuration bit picks the second oscillator pin function
// - peripheral clock equals cpu clock unless doze uses a ratio other than one
// - a stalled running clock is flagged so software can recover
// - software sets the switch request; hardware clears it when the switch is done
module clock_source_ctrl #(
	parameter int FAIL_CYCLES = `FAIL_SAFE_MONITOR_CYCLES
) (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	output logic irq,
	// configuration bits, taken once after reset
	input wire logic cfg_programmed,
	input wire clk_src_pkg::boot_cfg_type boot_cfg,
	// oscillators, asynchronous
	input wire logic internal_fast_rc,
	input wire logic low_power_rc,
	input wire logic primary_osc_pin,
	// second oscillator pin
	input wire logic pin_gpio_out,
	output logic second_osc_pin_o,
	output logic second_osc_pin_oe_n,
	output logic [1:0] crystal_amp,
	// derived clock enables and status
	output logic selected_osc_clock_en,
	output logic cpu_clk_en,
	output logic peripheral_clock_en,
	output logic pll_output_en,
	output logic vco_en,
	output logic clk_fail
);
	logic [2:0] sync1_q, sync2_q, sync3_q;
	logic rc_t, lowpwr_t, pri_t, rc16_t, rcdiv_t, pll_t, vco_t, cpu_t, dz_t;
	logic [7:0] tick_by_src;
	logic old_t, new_t, new_ok, pll_sel_pri, new_is_pll;
	logic [2:0] pll_src;
	logic [11:0] in_div, out_div, mul, both_div;
	clk_src_pkg::div_cfg_type div_q, div_d;
	clk_src_pkg::boot_cfg_type boot_q, boot_d;
	clk_src_pkg::sw_state_type sw_q, sw_d;
	logic [8:0] fb_q, fb_d;
	logic [2:0] aux_q, aux_d, new_src_q, new_src_d, cur_src_q, cur_src_d;
	logic swreq_q, swreq_d, loaded_q, loaded_d, swreq_clr, done, fail_evt;
	logic [1:0] stat_q, stat_d, mask_q, mask_d, stat_clr;
	logic [15:0] fail_cnt_q, fail_cnt_d;
	logic [7:0] lock_cnt_q, lock_cnt_d;
	logic locked, pll_cfg_wr, pll_sel_q;
	logic req, wr_fire, ack_d, irq_d, sys_d, clko_q, clko_d;
	logic [31:0] rdat_d;
	logic [1:0] amp_d;
	logic pin_o_d, pin_oe_n_d, pri_used;

	// two-stage synchronisers; edges are taken between stages two and three
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
		end else begin
			sync1_q <= {primary_osc_pin, low_power_rc, internal_fast_rc};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end
	assign rc_t = sync2_q[0] & ~sync3_q[0];
	assign lowpwr_t = sync2_q[1] & ~sync3_q[1];
	assign pri_t = sync2_q[2] & ~sync3_q[2];

	// derived source ticks
	tick_divider #(.W(9)) u_rc16 (
		.clk(clk),
		.rst_n(rst_n),
		.in_tick(rc_t),
		.ratio(`RC16_RATIO),
		.out_tick(rc16_t)
	);
	tick_divider #(.W(9)) u_rcdiv (
		.clk(clk),
		.rst_n(rst_n),
		.in_tick(rc_t),
		.ratio(9'h001 << div_q.frcdiv),
		.out_tick(rcdiv_t)
	);

	// pll follows the target while a switch is pending
	assign pll_src = (sw_q != clk_src_pkg::SW_IDLE) ? new_src_q : cur_src_q;
	assign pll_sel_pri = (pll_src == `SRC_PRI_PLL);
	assign in_div = 12'(div_q.pre) + `IN_DIV_ADD;
	assign out_div = 12'({div_q.post, 1'b0}) + 12'h002;
	assign mul = 12'(fb_q) + `MUL_ADD;
	assign both_div = 12'(in_div * out_div);

	rate_scaler #(.W(12)) u_pll (
		.clk(clk),
		.rst_n(rst_n),
		.in_tick(pll_sel_pri ? pri_t : rcdiv_t),
		.mul(mul),
		.div(both_div),
		.out_tick(pll_t)
	);
	rate_scaler #(.W(12)) u_vco (
		.clk(clk),
		.rst_n(rst_n),
		.in_tick(pll_sel_pri ? pri_t : rcdiv_t),
		.mul(mul),
		.div(in_div),
		.out_tick(vco_t)
	);

	// the reserved code carries no tick, so a switch to it never completes
	assign tick_by_src = {rcdiv_t, rc16_t, lowpwr_t, 1'b0, pll_t, pri_t, pll_t, rc_t};
	assign old_t = tick_by_src[cur_src_q];
	assign new_t = tick_by_src[new_src_q];
	assign new_is_pll = (new_src_q == `SRC_PRI_PLL) || (new_src_q == `SRC_RC_PLL);
	assign locked = (lock_cnt_q == `LOCK_TICKS);
	assign new_ok = new_t && (locked || !new_is_pll);

	// cpu and doze dividers
	tick_divider #(.W(9)) u_cpu (
		.clk(clk),
		.rst_n(rst_n),
		.in_tick(sys_d),
		.ratio(`CPU_RATIO),
		.out_tick(cpu_t)
	);
	tick_divider #(.W(9)) u_doze (
		.clk(clk),
		.rst_n(rst_n),
		.in_tick(cpu_t),
		.ratio(9'h001 << div_q.doze),
		.out_tick(dz_t)
	);

	// bus decode: ack one cycle after the request, writes land on the ack edge
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_fire = req & wb_we_i & wb_ack_o;
	assign pll_cfg_wr = wr_fire && (wb_adr_i == `ADR_DIV || wb_adr_i == `ADR_FBDIV);

	always_comb begin
		ack_d = req & ~wb_ack_o;
		rdat_d = 32'h0;
		if (ack_d) begin
			unique case (wb_adr_i)
				`ADR_CTRL: begin
					rdat_d[`CTRL_NEW +: 3] = new_src_q;
					rdat_d[`CTRL_CUR +: 3] = cur_src_q;
					rdat_d[`CTRL_SWREQ] = swreq_q;
					rdat_d[`CTRL_LOCK] = locked;
				end
				`ADR_DIV: begin
					rdat_d[`DIV_PRE +: 5] = div_q.pre;
					rdat_d[`DIV_POST +: 2] = div_q.post;
					rdat_d[`DIV_FRCDIV +: 3] = div_q.frcdiv;
					rdat_d[`DIV_DOZEN] = div_q.doze_en;
					rdat_d[`DIV_DOZE +: 3] = div_q.doze;
				end
				`ADR_FBDIV: rdat_d[8:0] = fb_q;
				`ADR_AUX: rdat_d[2:0] = aux_q;
				`ADR_STAT: rdat_d[1:0] = stat_q;
				`ADR_MASK: rdat_d[1:0] = mask_q;
				default: rdat_d = 32'h0;
			endcase
		end
	end

	// register writes and sticky status
	always_comb begin
		div_d = div_q;
		fb_d = fb_q;
		aux_d = aux_q;
		new_src_d = new_src_q;
		mask_d = mask_q;
		stat_clr = 2'h0;
		swreq_d = swreq_clr ? 1'b0 : swreq_q;
		if (wr_fire) begin
			unique case (wb_adr_i)
				`ADR_CTRL: begin
					if (wb_sel_i[0]) new_src_d = wb_dat_i[`CTRL_NEW +: 3];
					if (wb_sel_i[1]) swreq_d = wb_dat_i[`CTRL_SWREQ];
				end
				`ADR_DIV: begin
					if (wb_sel_i[0]) begin
						div_d.pre = wb_dat_i[`DIV_PRE +: 5];
						div_d.post = wb_dat_i[`DIV_POST +: 2];
					end
					if (wb_sel_i[1]) begin
						div_d.frcdiv = wb_dat_i[`DIV_FRCDIV +: 3];
						div_d.doze_en = wb_dat_i[`DIV_DOZEN];
						div_d.doze = wb_dat_i[`DIV_DOZE +: 3];
					end
				end
				`ADR_FBDIV: begin
					if (wb_sel_i[0]) fb_d[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) fb_d[8] = wb_dat_i[8];
				end
				`ADR_AUX: if (wb_sel_i[0]) aux_d = wb_dat_i[2:0];
				`ADR_STAT: if (wb_sel_i[0]) stat_clr = wb_dat_i[1:0];
				`ADR_MASK: if (wb_sel_i[0]) mask_d = wb_dat_i[1:0];
				default: stat_clr = 2'h0;
			endcase
		end
		// a new event beats a clear in the same cycle
		stat_d = (stat_q & ~stat_clr) | {done, fail_evt};
		irq_d = |(stat_d & mask_d);
	end

	// switch sequencer: finish the old pulse, then start on a whole new one
	always_comb begin
		sw_d = sw_q;
		cur_src_d = cur_src_q;
		boot_d = boot_q;
		loaded_d = 1'b1;
		sys_d = 1'b0;
		done = 1'b0;
		swreq_clr = 1'b0;
		unique case (sw_q)
			clk_src_pkg::SW_IDLE: begin
				sys_d = old_t;
				if (swreq_q && loaded_q) sw_d = clk_src_pkg::SW_WAIT_OLD;
			end
			clk_src_pkg::SW_WAIT_OLD: begin
				sys_d = old_t;
				if (old_t) sw_d = clk_src_pkg::SW_WAIT_NEW;
			end
			clk_src_pkg::SW_WAIT_NEW: begin
				if (new_ok) begin
					sys_d = 1'b1;
					cur_src_d = new_src_q;
					sw_d = clk_src_pkg::SW_IDLE;
					done = 1'b1;
					swreq_clr = 1'b1;
				end
			end
		endcase
		if (!loaded_q) begin
			boot_d = boot_cfg;
			cur_src_d = cfg_programmed ? boot_cfg.initial_source_select : `SRC_RC_DIVN;
		end
		// a silent clock, including a target that never starts, falls back to rc
		fail_evt = loaded_q && (fail_cnt_q == 16'(FAIL_CYCLES));
		fail_cnt_d = (sys_d || fail_evt || !loaded_q) ? 16'h0000 : fail_cnt_q + 16'h0001;
		if (fail_evt) begin
			cur_src_d = `SRC_RC;
			sw_d = clk_src_pkg::SW_IDLE;
			sys_d = 1'b0;
			done = 1'b0;
			swreq_clr = 1'b1;
		end
		lock_cnt_d = lock_cnt_q;
		// lock restarts when the pll input changes, so a pending pll target can still lock
		if (pll_cfg_wr || pll_sel_pri != pll_sel_q) begin
			lock_cnt_d = 8'h00;
		end else if (pll_t && !locked) begin
			lock_cnt_d = lock_cnt_q + 8'h01;
		end
	end

	// pin and amplifier: the mode field matters only for primary sources
	always_comb begin
		pri_used = (cur_src_q[2:1] == 2'h1) || (sw_q != clk_src_pkg::SW_IDLE && new_src_q[2:1] == 2'h1);
		amp_d = 2'h0;
		if (pri_used && boot_q.primary_osc_mode == `MODE_HIGH_SPEED) amp_d = 2'h2;
		if (pri_used && boot_q.primary_osc_mode == `MODE_CRYSTAL) amp_d = 2'h1;
		clko_d = sys_d ? ~clko_q : clko_q;
		// a crystal owns the pin; otherwise the configuration bit chooses its use
		pin_oe_n_d = (amp_d != 2'h0);
		pin_o_d = 1'b0;
		if (amp_d == 2'h0) pin_o_d = boot_q.osc_pin_function_bit ? pin_gpio_out : clko_q;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_q <= {`RST_DOZE, 1'b0, `RST_FRCDIV, `RST_POST, `RST_PRE};
			fb_q <= `RST_FB;
			aux_q <= `RST_AUX;
			new_src_q <= `SRC_RC_DIVN;
			cur_src_q <= `SRC_RC_DIVN;
			boot_q <= '0;
			loaded_q <= 1'b0;
			swreq_q <= 1'b0;
			stat_q <= 2'h0;
			mask_q <= 2'h0;
			sw_q <= clk_src_pkg::SW_IDLE;
			fail_cnt_q <= 16'h0000;
			lock_cnt_q <= 8'h00;
			pll_sel_q <= 1'b0;
			clko_q <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			irq <= 1'b0;
			crystal_amp <= 2'h0;
			second_osc_pin_o <= 1'b0;
			second_osc_pin_oe_n <= 1'b1;
			selected_osc_clock_en <= 1'b0;
			cpu_clk_en <= 1'b0;
			peripheral_clock_en <= 1'b0;
			pll_output_en <= 1'b0;
			vco_en <= 1'b0;
			clk_fail <= 1'b0;
		end else begin
			div_q <= div_d;
			fb_q <= fb_d;
			aux_q <= aux_d;
			new_src_q <= new_src_d;
			cur_src_q <= cur_src_d;
			boot_q <= boot_d;
			loaded_q <= loaded_d;
			swreq_q <= swreq_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			sw_q <= sw_d;
			fail_cnt_q <= fail_cnt_d;
			lock_cnt_q <= lock_cnt_d;
			pll_sel_q <= pll_sel_pri;
			clko_q <= clko_d;
			wb_ack_o <= ack_d;
			wb_dat_o <= rdat_d;
			irq <= irq_d;
			crystal_amp <= amp_d;
			second_osc_pin_o <= pin_o_d;
			second_osc_pin_oe_n <= pin_oe_n_d;
			selected_osc_clock_en <= sys_d;
			cpu_clk_en <= cpu_t;
			peripheral_clock_en <= div_q.doze_en ? dz_t : cpu_t;
			pll_output_en <= pll_t;
			vco_en <= vco_t;
			clk_fail <= stat_d[`ST_FAIL];
		end
	end

	// checking helpers
	logic [1:0] h_cnt_q;
	always_ff @(posedge clk) begin
		if (!rst_n) h_cnt_q <= 2'h0;
		else h_cnt_q <= (cpu_t ? 2'h0 : h_cnt_q) + {1'b0, sys_d};
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_cpu_half_rate: assert property (cpu_t |-> h_cnt_q == 2'h2)
		else $error("cpu enable not at half the oscillator rate");
	a_src_decode: assert property ((sw_q == clk_src_pkg::SW_IDLE && cur_src_q == `SRC_LOWPWR && !fail_evt)
		|=> selected_osc_clock_en == $past(lowpwr_t))
		else $error("low-power code does not follow its oscillator");
	a_erased_boot: assert property (@(posedge clk) disable iff (1'b0)
		$rose(rst_n) && !cfg_programmed |=> cur_src_q == `SRC_RC_DIVN)
		else $error("erased device not on rc with programmable divider");
	a_amp_mode: assert property ((cur_src_q == `SRC_PRI && boot_q.primary_osc_mode == `MODE_HIGH_SPEED)
		|=> crystal_amp == 2'h2 && second_osc_pin_oe_n)
		else $error("high-speed crystal mode not applied");
	a_pin_gpio: assert property ((boot_q.osc_pin_function_bit && cur_src_q == `SRC_RC && sw_q == clk_src_pkg::SW_IDLE)
		|=> !second_osc_pin_oe_n && second_osc_pin_o == $past(pin_gpio_out))
		else $error("second pin not driven as general output");
	a_periph_cpu: assert property (!div_d.doze_en |=> peripheral_clock_en == cpu_clk_en)
		else $error("peripheral enable differs from cpu outside doze");
	a_fail_fallback: assert property (fail_evt |=> stat_q[`ST_FAIL] && cur_src_q == `SRC_RC ##1 clk_fail)
		else $error("clock failure not flagged or not recovered to rc");
	a_switch_done: assert property ((sw_q == clk_src_pkg::SW_WAIT_NEW && new_ok && !fail_evt)
		|=> cur_src_q == $past(new_src_q) && stat_q[`ST_DONE] && (!swreq_q || $past(wr_fire)))
		else $error("switch completion not reported");
	a_no_runt: assert property ((sw_q == clk_src_pkg::SW_WAIT_NEW && !new_ok) |=> !selected_osc_clock_en)
		else $error("clock pulse emitted between sources");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held longer than one cycle");

	c_switch: cover property (sw_q == clk_src_pkg::SW_WAIT_NEW && new_ok);
	c_fail: cover property (fail_evt);
	c_doze: cover property (peripheral_clock_en && div_q.doze_en && div_q.doze != 3'h0);
	c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ### osc_sources.sv
// behavioural oscillators at the far side: fast rc, low-power rc, primary
// assumes clk is the system clock; the square waves change just after its rising edge
`default_nettype none
module osc_sources (
	// system
	input wire logic clk,
	// half periods in clk cycles, per oscillator
	input wire logic [2:0][7:0] half,
	input wire logic [2:0] run,
	// outputs: [0] fast rc, [1] low-power rc, [2] primary
	output logic [2:0] osc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt [3];
	initial begin
		osc = 3'h0;
		cnt = '{8'h00, 8'h00, 8'h00};
	end
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			// a dead oscillator sits low, so the monitor sees no edges at all
			if (run[i] !== 1'b1) begin
				osc[i] <= 1'b0;
				cnt[i] <= 8'h00;
			end else if (cnt[i] + 8'h01 >= half[i]) begin
				osc[i] <= ~osc[i];
				cnt[i] <= 8'h00;
			end else begin
				cnt[i] <= cnt[i] + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb_system_clock_source_and_pll.sv
// self-checking bench for the clock source controller
// assumes the design files and osc_sources.sv are compiled first
`include "clk_src_defs.svh"
`default_nettype none
module tb_system_clock_source_and_pll;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, cfg_programmed;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	clk_src_pkg::boot_cfg_type boot_cfg;
	logic [2:0] osc, run, osc_p;
	logic [2:0][7:0] half;
	logic pin_gpio_out, second_osc_pin_o, second_osc_pin_oe_n, lastp;
	logic [1:0] crystal_amp, ea;
	logic selected_osc_clock_en, cpu_clk_en, peripheral_clock_en, pll_output_en, vco_en, clk_fail;
	int errors, check_count, n, tg, e, m, n1, n2;
	int cnt[8], base[8], d[8];
	localparam logic [6:0] boot_tab [5] = '{7'h14, 7'h55, 7'h53, 7'h51, 7'h45};
	localparam logic [7:0] ra [7] = '{`ADR_CTRL, `ADR_DIV, `ADR_FBDIV, `ADR_AUX, `ADR_STAT, `ADR_MASK, 8'h18};
	localparam logic [31:0] rv [7] = '{32'h77, 32'h3040, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	localparam logic [15:0] pll_tab [3] = '{16'h0002, 16'h1107, 16'h3003};
	localparam logic [2:0] sw_tab [8] = '{3'h6, 3'h5, 3'h2, 3'h3, 3'h0, 3'h1, 3'h0, 3'h7};

	// fail limit raised: the rc-pll lock wait is long at these oscillator rates
	clock_source_ctrl #(.FAIL_CYCLES(2000)) dut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .irq, .cfg_programmed, .boot_cfg,
		.internal_fast_rc(osc[0]), .low_power_rc(osc[1]), .primary_osc_pin(osc[2]), .pin_gpio_out,
		.second_osc_pin_o, .second_osc_pin_oe_n, .crystal_amp, .selected_osc_clock_en, .cpu_clk_en,
		.peripheral_clock_en, .pll_output_en, .vco_en, .clk_fail);
	osc_sources src (.clk, .half, .run, .osc);

	always #10 clk = ~clk;

	// event counters: [0] sel [1] cpu [2] periph [3] pll out [4] vco [5..7] oscillator edges
	always @(posedge clk) begin
		logic [7:0] ev;
		ev = {osc & ~osc_p, vco_en, pll_output_en, peripheral_clock_en, cpu_clk_en, selected_osc_clock_en};
		for (int i = 0; i < 8; i++)
			cnt[i] += int'(ev[i] === 1'b1);
		osc_p = osc;
	end

	task automatic conclude;
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
		check_count++;
		if (g !== ex) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, ex, g);
		end
	endtask

	// rates are counted over a window, so a few ticks of edge effect are allowed
	task automatic near(input string nm, input int ex, input int g);
		check_count++;
		if (g > ex + 3 || g < ex - 3) begin
			errors++;
			$display("mismatch %s expected %0d seen %0d", nm, ex, g);
		end
	endtask

	// one classic cycle; entered just after a rising edge, leaves one idle cycle
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rq);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		wb_sel_i <= 4'h3;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		rq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
		if (k >= 20) begin
			errors++;
			conclude();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		wb(a, 1'b1, wd, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] rq);
		wb(a, 1'b0, 32'h0, rq);
	endtask

	task automatic boot(input logic [6:0] b);
		rst_n <= 1'b0;
		cfg_programmed <= b[6];
		boot_cfg <= b[5:0];
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	task automatic meas(input int k);
		base = cnt;
		repeat (k) @(posedge clk);
		foreach (d[i])
			d[i] = cnt[i] - base[i];
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		cfg_programmed = 1'b0;
		boot_cfg = '0;
		pin_gpio_out = 1'b1;
		half = {8'h05, 8'h14, 8'h08};
		run = 3'h7;
		osc_p = 3'h0;
		errors = 0;
		check_count = 0;
		foreach (cnt[i])
			cnt[i] = 0;
		for (int i = 0; i < 5; i++) begin
			boot(boot_tab[i]);
			repeat (4) @(posedge clk);
			rd(`ADR_CTRL, q);
			chk("cur", boot_tab[i][6] ? boot_tab[i][5:3] : 3'h7, q[6:4]);
			ea = (boot_tab[i][6] && boot_tab[i][5:4] == 2'h1) ? boot_tab[i][2:1] : 2'h0;
			chk("amp", ea, crystal_amp);
			chk("oe_n", ea != 2'h0, second_osc_pin_oe_n);
			tg = 0;
			lastp = second_osc_pin_o;
			repeat (100) begin
				@(posedge clk);
				if (second_osc_pin_o !== lastp)
					tg++;
				lastp = second_osc_pin_o;
			end
			if (ea == 2'h0)
				chk("pin", 1, boot_tab[i][0] ? second_osc_pin_o : tg > 2);
		end
		boot(7'h00);
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], q);
			chk("reset", rv[i], q & ~32'h200);
		end
		wr(8'h18, 32'hffff);
		rd(8'h18, q);
		chk("unmapped", 0, q);
		wr(`ADR_AUX, 32'h7);
		rd(`ADR_AUX, q);
		chk("aux", 32'h7, q);
		meas(1600);
		near("sel", d[5], d[0]);
		near("cpu", d[0] / 2, d[1]);
		near("per", d[1], d[2]);
		wr(`ADR_DIV, 32'h1840);
		meas(1600);
		near("doze", d[1] / 2, d[2]);
		wr(`ADR_DIV, 32'h0840);
		meas(1600);
		near("doze1", d[1], d[2]);
		for (int i = 0; i < 3; i++) begin
			n1 = pll_tab[i][15:12] + 2;
			n2 = 2 * (pll_tab[i][11:8] + 1);
			m = pll_tab[i][7:0] + 2;
			wr(`ADR_DIV, {16'h0, 8'h0, pll_tab[i][9:8], 1'b0, pll_tab[i][15:12] & 5'h1f});
			wr(`ADR_FBDIV, {24'h0, pll_tab[i][7:0]});
			repeat (100) @(posedge clk);
			meas(1600);
			near("vco", d[5] * m / n1, d[4]);
			near("pllo", d[5] * m / (n1 * n2), d[3]);
		end
		wr(`ADR_DIV, 32'h0100);
		wr(`ADR_FBDIV, 32'h2);
		wr(`ADR_MASK, 32'h2);
		foreach (sw_tab[i]) begin
			wr(`ADR_CTRL, 32'h100 | sw_tab[i]);
			n = 0;
			do begin
				rd(`ADR_CTRL, q);
				n++;
			end while (q[8] && n < 1000);
			if (q[8] === 1'b1) begin
				errors++;
				conclude();
			end
			chk("switch", sw_tab[i], q[6:4]);
			chk("irq", 1, irq);
			rd(`ADR_STAT, q);
			chk("done", 32'h2, q & 32'h2);
			wr(`ADR_STAT, 32'h2);
			repeat (3) @(posedge clk);
			chk("irq clr", 0, irq);
			meas(1600);
			case (sw_tab[i])
				3'h0: e = d[5];
				3'h6: e = d[5] / 16;
				3'h5: e = d[6];
				3'h2, 3'h3: e = d[7];
				default: e = d[5] / 2;
			endcase
			near("rate", e, d[0]);
		end
		wr(`ADR_MASK, 32'h1);
		run <= 3'h6;
		n = 0;
		while (clk_fail !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("fail", 1, clk_fail);
		chk("fail irq", 1, irq);
		rd(`ADR_CTRL, q);
		chk("fallback", 0, q[6:4]);
		run <= 3'h7;
		wr(`ADR_STAT, 32'h1);
		rd(`ADR_STAT, q);
		chk("fail clr", 0, q[0]);
		conclude();
	end
endmodule
`default_nettype wire
